// ### bench/fpu_flags_control_exceptions_bench.sv
`timescale 1ns/1ns
module fpu_flags_control_exceptions_bench
    import fpu_flags_pkg::*;
;
    typedef struct packed {
        op_req_t    r;
        logic [3:0] cc;
    } row_t;

    logic        clk;
    logic        arst_n;
    logic [5:0]  exc_raise;
    op_req_t     req;
    logic [31:0] instr_addr, oper_addr, inst_ptr_ff, data_ptr_ff;
    logic [10:0] opcode, opcode_ptr_ff;
    logic [15:0] ctl_word_ff;
    logic [3:0]  cc_ff;
    logic [5:0]  exc_flags_ff;
    logic        error_summary_ff, error_n_ff, round_active_ff, data_ptr_valid_ff;
    round_sel_t  eff_round_ff;
    logic [6:0]  sig_bits_ff;
    int          bad_count = 0;
    int          total_checks = 0;
    row_t        rows[11];
    logic [3:0]  cmp_tab[4] = '{4'h0, 4'h1, 4'h8, 4'hD};
    logic [3:0]  cls_tab[7] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hC};
    logic [6:0]  sig_tab[4] = '{7'h18, 7'h40, 7'h35, 7'h40};
    logic [15:0] ctl_val;
    op_req_t     r;

    host_model host_model_i (
        .clk, .error_n(error_n_ff), .req, .instr_addr, .oper_addr, .opcode
    );

    fpu_flags_control_exceptions fpu_flags_control_exceptions_i (
        .clk, .arst_n, .req, .instr_addr, .oper_addr, .opcode, .exc_raise,
        .ctl_word_ff, .cc_ff, .exc_flags_ff, .error_summary_ff, .error_n_ff,
        .round_active_ff, .eff_round_ff, .sig_bits_ff, .inst_ptr_ff, .data_ptr_ff,
        .opcode_ptr_ff, .data_ptr_valid_ff
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize

    // Plain command with fixed pointers
    task automatic op(input op_kind_t k, input round_use_t u, input logic [15:0] d);
        op_req_t q;
        q = '0;
        q.kind = k;
        q.rnd_use = u;
        q.data = d;
        host_model_i.issue(q, 32'h0000_1000, 11'h000);
    endtask : op

    // Exception pulse lasts exactly one edge
    task automatic pulse(input logic [5:0] e);
        @(posedge clk);
        #1;
        exc_raise = e;
        @(posedge clk);
        #1;
        exc_raise = '0;
    endtask : pulse

    // Watchdog: a hang ends the run as a failure
    initial begin
        for (int n = 0; n < 20000; n++) @(posedge clk);
        bad_count++;
        summarize();
    end

    // Hold reset, release it off the edge, then check the presence state
    task automatic do_reset(input int n);
        arst_n = 1'b0;
        repeat (n) @(posedge clk);
        #1;
        arst_n = 1'b1;
        chk(ctl_word_ff, 32'h0000_037E);
        chk(exc_flags_ff, 32'h0000_0001);
        chk(error_summary_ff, 32'h1);
        chk(error_n_ff, 32'h0);
        chk(cc_ff, 32'h0);
        chk(data_ptr_valid_ff, 32'h0);
        $display("test reset done");
    endtask : do_reset

    initial begin
        exc_raise = '0;
        do_reset(8);
        // No-wait init clears the presence error so the host stops trapping
        op(OP_INIT, RND_NONE, 16'h0000);
        // Rows: four compares then every class with both signs mixed in
        for (int i = 0; i < 11; i++) begin
            rows[i] = '0;
            rows[i].r.has_mem = i[0];
            if (i < 4) begin
                rows[i].r.kind = OP_COMPARE;
                rows[i].r.cmp = cmp_res_t'(i);
                rows[i].cc = cmp_tab[i];
            end else begin
                rows[i].r.kind = OP_EXAMINE;
                rows[i].r.cls = op_class_t'(i - 4);
                rows[i].r.sign = i[0];
                rows[i].cc = cls_tab[i-4] | {2'h0, i[0], 1'b0};
            end
        end
        for (int i = 0; i < 11; i++) begin
            host_model_i.issue(rows[i].r, 32'(32'h4000 + i * 16), 11'(i + 5));
            chk(cc_ff, rows[i].cc);
            chk(inst_ptr_ff, 32'(32'h4000 + i * 16));
            chk(opcode_ptr_ff, 32'(i + 5));
            chk(data_ptr_valid_ff, 32'(rows[i].r.has_mem));
            if (rows[i].r.has_mem)
                chk(data_ptr_ff, 32'(32'h4100 + i * 16));
        end
        $display("test rows done");
        // Every rounding and precision code, spare bit set on each load
        for (int rnd_i = 0; rnd_i < 4; rnd_i++) begin
            for (int prc_i = 0; prc_i < 4; prc_i++) begin
                ctl_val = {3'h0, 1'b1, 2'(rnd_i), 2'(prc_i), 8'h3F};
                op(OP_LOAD_CTL, RND_NONE, ctl_val);
                chk(ctl_word_ff, ctl_val);
                op(OP_ARITH, RND_BASIC, 16'h0000);
                chk(round_active_ff, 32'h1);
                chk(eff_round_ff, 32'(rnd_i));
                chk(sig_bits_ff, sig_tab[prc_i]);
                op(OP_OTHER, RND_FINAL, 16'h0000);
                chk(eff_round_ff, 32'(rnd_i));
                chk(sig_bits_ff, 32'h40);
                op(OP_OTHER, RND_NONE, 16'h0000);
                chk(round_active_ff, 32'h0);
                chk(eff_round_ff, 32'h0);
            end
        end
        $display("test control done");
        op(OP_INIT, RND_NONE, 16'h0000);
        chk(ctl_word_ff, 32'h0000_037F);
        chk(exc_flags_ff, 32'h0);
        chk(cc_ff, 32'h0);
        op(OP_LOAD_CTL, RND_NONE, 16'h037B);
        pulse(6'h02);
        chk(exc_flags_ff, 32'h02);
        chk(error_summary_ff, 32'h0);
        @(posedge clk);
        #1;
        chk(error_n_ff, 32'h1);
        pulse(6'h04);
        chk(exc_flags_ff, 32'h06);
        chk(error_summary_ff, 32'h1);
        @(posedge clk);
        #1;
        chk(error_n_ff, 32'h0);
        op(OP_CLEAR_EXC, RND_NONE, 16'h0000);
        chk(exc_flags_ff, 32'h0);
        chk(error_summary_ff, 32'h0);
        $display("test exceptions done");
        host_model_i.issue(rows[1].r, 32'h0000_5000, 11'h001);
        chk(cc_ff, 32'h1);
        op(OP_PREM_INC, RND_NONE, 16'h0000);
        chk(cc_ff, 32'h0);
        r = rows[3].r;
        r.seg_fault = 1'b1;
        host_model_i.issue(r, 32'h0000_6000, 11'h002);
        chk(cc_ff, 32'h0);
        chk(inst_ptr_ff, 32'h0000_1000);
        $display("test fault done");
        // Mid-run reset leaves an error pending, so the next compare is trapped
        do_reset(2);
        host_model_i.issue(rows[1].r, 32'h0000_5000, 11'h001);
        chk(cc_ff, 32'h0);
        chk(host_model_i.trap_count, 32'h1);
        op(OP_INIT, RND_NONE, 16'h0000);
        chk(host_model_i.trap_count, 32'h1);
        host_model_i.task_swapped_flag = 1'b1;
        host_model_i.issue(rows[1].r, 32'h0000_5000, 11'h001);
        chk(cc_ff, 32'h0);
        chk(host_model_i.trap_count, 32'h2);
        host_model_i.task_swapped_flag = 1'b0;
        host_model_i.issue(rows[1].r, 32'h0000_5000, 11'h001);
        chk(cc_ff, 32'h1);
        $display("test traps done");
        summarize();
    end
endmodule : fpu_flags_control_exceptions_bench

// ### bench/host_model.sv
`timescale 1ns/1ns
// Host side: issues one command at a time with its pointer values
module host_model
    import fpu_flags_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   error_n,
    output op_req_t     req,
    output logic [31:0] instr_addr,
    output logic [31:0] oper_addr,
    output logic [10:0] opcode
);
    // Last byte of the flat data segment the host works in
    localparam logic [31:0] SEG_END = 32'h0000_FFFF;

    // Host control register zero flags and a count of trapped opcodes
    logic software_trap_req;
    logic task_swapped_flag;
    int   trap_count;

    initial begin
        req = '0;
        instr_addr = '0;
        oper_addr = '0;
        opcode = '0;
        software_trap_req = 1'b0;
        task_swapped_flag = 1'b0;
        trap_count = 0;
    end

    // One cycle per command, then idle so the device sees it once
    task automatic issue(input op_req_t r, input logic [31:0] ia, input logic [10:0] opc);
        logic trap;
        @(posedge clk);
        #1;
        // emulation or swapped task traps every opcode
        trap = software_trap_req || task_swapped_flag;
        // pending error traps the next waiting opcode
        // no-wait init and clear pass regardless
        if (error_n !== 1'b1 && r.kind != OP_INIT && r.kind != OP_CLEAR_EXC) begin
            trap = 1'b1;
        end
        // operand never placed within 108 bytes of segment end
        if (r.has_mem && ia + 32'h0000_0100 > SEG_END - 32'h0000_006C) begin
            trap = 1'b1;
        end
        // A trapped opcode never reaches the device
        if (trap) begin
            trap_count++;
            r = '0;
        end
        req = r;
        instr_addr = ia;
        opcode = opc;
        // flat 32-bit image only; no operand: junk address
        oper_addr = r.has_mem ? ia + 32'h0000_0100 : ~oper_addr;
        @(posedge clk);
        #1;
        req = '0;
    endtask : issue
endmodule : host_model

// ### src/fpu_flags_control_exceptions.sv
`timescale 1ns/1ns
`include "fpu_flags_map.svh"
// Operation
// - Compare sets bits three, two, zero: 000 gt, 001 lt, 100 eq, 111 unordered.
// - Examine encodes class and sign of stack top; sign in bit one.
// - Control word bits five to zero mask the six exceptions.
// - Bit twelve is spare, cleared by reset and init, loadable.
// - Bits eleven and ten select the rounding mode.
// - Rounding selection affects only operations rounding their final result.
// - Bits nine and eight may reduce significand precision below 64 bits.
// - Precision selection applies only to add, sub, div, mul, sqrt.
// - Segment-limit fault leaves opcode unexecuted and pointers unchanged.
// - Saved pointers identify the failing instruction despite parallel execution.
// - Unmasked exception sets its flag, error summary and error output.
// - Reset sets invalid flag and summary, clears invalid mask, asserts error.
// - Condition bits clear after reset, init and incomplete remainder.
module fpu_flags_control_exceptions
    import fpu_flags_pkg::*;
#(
    parameter int ADDR_W = 32,
    parameter int OPC_W  = 11
) (
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire op_req_t             req,
    input  wire logic [ADDR_W-1:0]   instr_addr,
    input  wire logic [ADDR_W-1:0]   oper_addr,
    input  wire logic [OPC_W-1:0]    opcode,
    input  wire logic [5:0]          exc_raise,
    output logic      [15:0]         ctl_word_ff,
    output logic      [3:0]          cc_ff,
    output logic      [5:0]          exc_flags_ff,
    output logic                     error_summary_ff,
    output logic                     error_n_ff,
    output logic                     round_active_ff,
    output round_sel_t               eff_round_ff,
    output logic      [6:0]          sig_bits_ff,
    output logic      [ADDR_W-1:0]   inst_ptr_ff,
    output logic      [ADDR_W-1:0]   data_ptr_ff,
    output logic      [OPC_W-1:0]    opcode_ptr_ff,
    output logic                     data_ptr_valid_ff
);

    // Refuse widths the pointer registers cannot serve
    if (ADDR_W < 16 || ADDR_W > 32 || OPC_W < 1 || OPC_W > 16) begin : gen_width_check
        $error("fpu_flags_control_exceptions: unsupported width");
    end

    // Compare result to bits {three, two, one, zero}; bit one left clear
    function automatic logic [3:0] cmp_code(input cmp_res_t r);
        case (r)
            CMP_GT:  cmp_code = 4'h0;
            CMP_LT:  cmp_code = 4'h1;
            CMP_EQ:  cmp_code = 4'h8;
            default: cmp_code = 4'hD;
        endcase
    endfunction : cmp_code

    // Class code with sign folded into bit one
    function automatic logic [3:0] class_code(input op_class_t c, input logic s);
        logic [3:0] base;
        case (c)
            CLS_UNSUP:  base = 4'h0;
            CLS_NAN:    base = 4'h1;
            CLS_NORMAL: base = 4'h4;
            CLS_INF:    base = 4'h5;
            CLS_ZERO:   base = 4'h8;
            CLS_EMPTY:  base = 4'h9;
            default:    base = 4'hC;
        endcase
        class_code = base | {2'h0, s, 1'b0};
    endfunction : class_code

    // Significand width for a precision code; reserved code runs extended
    function automatic logic [6:0] sig_width(input logic [1:0] prec_code);
        case (prec_code)
            PREC_24: sig_width = `SIG_BITS_24;
            PREC_53: sig_width = `SIG_BITS_53;
            default: sig_width = `SIG_BITS_64;
        endcase
    endfunction : sig_width

    logic [5:0]  mask_w;
    logic [5:0]  unmasked;
    logic [5:0]  nxt_exc_flags;
    logic        nxt_summary;
    logic        is_init;
    logic        accepted;

    assign mask_w   = ctl_word_ff[`CTL_MASK_LSB +: `CTL_MASK_W];
    assign is_init  = (req.kind == OP_INIT);
    // Faulting opcode never executes, so it touches no state
    assign accepted = (req.kind != OP_NONE) && !req.seg_fault;

    assign unmasked = exc_raise & ~mask_w;

    // Flags: a raise in the same cycle as a clear survives it
    always_comb begin
        nxt_exc_flags = exc_flags_ff;
        nxt_summary   = error_summary_ff;
        if (accepted && (is_init || req.kind == OP_CLEAR_EXC)) begin
            nxt_exc_flags = 6'h00;
            nxt_summary   = 1'b0;
        end
        nxt_exc_flags = nxt_exc_flags | exc_raise;
        if (unmasked != 6'h00) begin
            nxt_summary = 1'b1;
        end
    end

    // Control word: reset clears invalid mask, init restores masked default
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_word_ff <= `CTL_RESET_VAL;
        end else if (accepted && is_init) begin
            ctl_word_ff <= `CTL_INIT_VAL;
        end else if (accepted && req.kind == OP_LOAD_CTL) begin
            // masks, spare bit and modes all loadable
            ctl_word_ff <= req.data;
        end
    end

    // Sticky exception flags and error summary
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            exc_flags_ff     <= `EXC_FLAGS_RESET;
            error_summary_ff <= 1'b1;
        end else begin
            exc_flags_ff     <= nxt_exc_flags;
            error_summary_ff <= nxt_summary;
        end
    end

    // Error pin follows summary one cycle later, active low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            error_n_ff <= 1'b0;
        end else begin
            error_n_ff <= ~error_summary_ff;
        end
    end

    // Condition code bits
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cc_ff <= `CC_RESET_VAL;
        end else if (accepted) begin
            case (req.kind)
                OP_COMPARE:  cc_ff <= cmp_code(req.cmp) & 4'hD;
                OP_EXAMINE:  cc_ff <= class_code(req.cls, req.sign);
                OP_INIT:     cc_ff <= `CC_RESET_VAL;
                OP_PREM_INC: cc_ff <= `CC_RESET_VAL;
                default:     cc_ff <= cc_ff;
            endcase
        end
    end

    // Effective rounding for the operation just issued
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            round_active_ff <= 1'b0;
            eff_round_ff    <= ROUND_NEAREST;
        end else if (accepted) begin
            // only final-rounding operations use the field
            round_active_ff <= (req.rnd_use != RND_NONE);
            eff_round_ff    <= (req.rnd_use != RND_NONE)
                ? round_sel_t'(ctl_word_ff[`CTL_ROUND_LSB +: 2]) : ROUND_NEAREST;
        end
    end

    // Effective significand width; others run extended
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sig_bits_ff <= `SIG_BITS_64;
        end else if (accepted) begin
            sig_bits_ff <= (req.rnd_use == RND_BASIC)
                ? sig_width(ctl_word_ff[`CTL_PREC_LSB +: 2]) : `SIG_BITS_64;
        end
    end

    // Pointers track the last executed numeric opcode; control forms keep
    // them so a handler still sees the instruction that raised the error
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            inst_ptr_ff       <= '0;
            data_ptr_ff       <= '0;
            opcode_ptr_ff     <= '0;
            data_ptr_valid_ff <= 1'b0;
        end else if (accepted && req.kind != OP_INIT && req.kind != OP_CLEAR_EXC
                     && req.kind != OP_LOAD_CTL) begin
            inst_ptr_ff       <= instr_addr;
            opcode_ptr_ff     <= opcode;
            // data pointer meaningless without memory operand
            data_ptr_valid_ff <= req.has_mem;
            if (req.has_mem) begin
                data_ptr_ff <= oper_addr;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    logic past_valid_ff;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            past_valid_ff <= 1'b0;
        end else begin
            past_valid_ff <= 1'b1;
        end
    end

    chk_compare_code: assert property (
        accepted && req.kind == OP_COMPARE && req.cmp == CMP_UNORD |=> cc_ff == 4'hD)
        else $error("compare unordered code wrong");

    chk_examine_sign: assert property (
        accepted && req.kind == OP_EXAMINE |=> cc_ff[1] == $past(req.sign))
        else $error("examine sign not in bit one");

    chk_mask_blocks: assert property (
        (exc_raise & ~mask_w) == 6'h00 && !error_summary_ff
        && !(accepted && req.kind == OP_LOAD_CTL) |=> !error_summary_ff)
        else $error("masked exception set summary");

    chk_init_spare: assert property (
        accepted && is_init |=> ctl_word_ff[`CTL_SPARE_BIT] == 1'b0)
        else $error("spare bit not cleared by init");

    chk_load_word: assert property (
        accepted && req.kind == OP_LOAD_CTL |=> ctl_word_ff == $past(req.data))
        else $error("control word load not taken as written");

    chk_round_gate: assert property (
        accepted && req.rnd_use == RND_NONE
        |=> !round_active_ff && eff_round_ff == ROUND_NEAREST)
        else $error("rounding applied to non-rounding op");

    chk_prec_basic: assert property (
        accepted && req.rnd_use != RND_BASIC |=> sig_bits_ff == `SIG_BITS_64)
        else $error("precision applied outside basic arithmetic");

    chk_fault_ptr: assert property (
        req.kind != OP_NONE && req.seg_fault |=> $stable(inst_ptr_ff) && $stable(cc_ff))
        else $error("faulted opcode changed state");

    chk_error_pin: assert property (
        past_valid_ff && unmasked != 6'h00 |=> ##1 !error_n_ff)
        else $error("error pin not asserted after unmasked exception");

    chk_summary_set: assert property (
        unmasked != 6'h00 |=> error_summary_ff)
        else $error("unmasked exception left summary clear");

    chk_reset_state: assert property (
        !past_valid_ff |-> exc_flags_ff[`EXC_INVALID_BIT] && error_summary_ff
        && !ctl_word_ff[`CTL_INV_MASK_BIT])
        else $error("reset presence state wrong");

    chk_prem_clear: assert property (
        accepted && req.kind == OP_PREM_INC |=> cc_ff == 4'h0)
        else $error("incomplete remainder left condition bits");

    chk_init_clear: assert property (
        accepted && is_init && exc_raise == 6'h00 |=> exc_flags_ff == 6'h00 && cc_ff == 4'h0)
        else $error("init left flags or condition bits");

    cov_unordered: cover property (accepted && req.kind == OP_COMPARE
        && req.cmp == CMP_UNORD);
    cov_error_raise: cover property (unmasked != 6'h00 ##2 !error_n_ff);
    cov_init_clear: cover property (!error_n_ff ##1 accepted && is_init);
    cov_seg_fault: cover property (req.kind == OP_ARITH && req.seg_fault);

endmodule : fpu_flags_control_exceptions

// ### src/fpu_flags_map.svh
`ifndef FPU_FLAGS_MAP_SVH
`define FPU_FLAGS_MAP_SVH

// Control word field positions
`define CTL_MASK_LSB     0
`define CTL_MASK_W       6
`define CTL_INV_MASK_BIT 0
`define CTL_PREC_LSB     8
`define CTL_ROUND_LSB    10
`define CTL_SPARE_BIT    12

// Control word values after hardware reset and after initialise
`define CTL_RESET_VAL    16'h037E
`define CTL_INIT_VAL     16'h037F

// Exception flag position and reset values of the sticky flags and condition bits
`define EXC_INVALID_BIT  0
`define EXC_FLAGS_RESET  6'h01
`define CC_RESET_VAL     4'h0

// Significand widths selected by the precision field
`define SIG_BITS_24      7'h18
`define SIG_BITS_53      7'h35
`define SIG_BITS_64      7'h40

`endif

// ### src/fpu_flags_pkg.sv
package fpu_flags_pkg;

    // Command presented by the execution unit, one per cycle
    typedef enum logic [3:0] {
        OP_NONE      = 4'h0,
        OP_LOAD_CTL  = 4'h1,
        OP_INIT      = 4'h2,
        OP_CLEAR_EXC = 4'h3,
        OP_COMPARE   = 4'h4,
        OP_EXAMINE   = 4'h5,
        OP_PREM_INC  = 4'h6,
        OP_ARITH     = 4'h7,
        OP_OTHER     = 4'h8
    } op_kind_t;

    typedef enum logic [1:0] {
        CMP_GT    = 2'h0,
        CMP_LT    = 2'h1,
        CMP_EQ    = 2'h2,
        CMP_UNORD = 2'h3
    } cmp_res_t;

    typedef enum logic [2:0] {
        CLS_UNSUP  = 3'h0,
        CLS_NAN    = 3'h1,
        CLS_NORMAL = 3'h2,
        CLS_INF    = 3'h3,
        CLS_ZERO   = 3'h4,
        CLS_EMPTY  = 3'h5,
        CLS_DENORM = 3'h6
    } op_class_t;

    // How an operation is governed by rounding and precision control
    typedef enum logic [1:0] {
        RND_NONE  = 2'h0,
        RND_FINAL = 2'h1,
        RND_BASIC = 2'h2
    } round_use_t;

    typedef enum logic [1:0] {
        ROUND_NEAREST = 2'h0,
        ROUND_DOWN    = 2'h1,
        ROUND_UP      = 2'h2,
        ROUND_CHOP    = 2'h3
    } round_sel_t;

    typedef enum logic [1:0] {
        PREC_24  = 2'h0,
        PREC_RSV = 2'h1,
        PREC_53  = 2'h2,
        PREC_64  = 2'h3
    } precision_sel_t;

    typedef struct packed {
        op_kind_t   kind;
        cmp_res_t   cmp;
        op_class_t  cls;
        logic       sign;
        round_use_t rnd_use;
        logic       has_mem;
        logic       seg_fault;
        logic [15:0] data;
    } op_req_t;

endpackage : fpu_flags_pkg
